// File: design/secp_config_port.sv
// Serial emphasis configuration port: shift register, strobe capture and
// the applied emphasis and equalizer settings.
// Assumes a host that clocks bits on serial_config_clock_in and raises
// config_load_strobe once shifting is done; clk is a free-running 40 MHz clock.
`timescale 1ns/1ps

// Summary of operation
// [R1] A five-stage shift register takes one serial data bit per advance.
// [R2] The register advances once per rising serial clock edge out of link reset, never otherwise.
// [R3] Host sends emphasis code most significant bit first, equalizer enable last.
// [R4] Strobe rising edge captures register contents held just before that edge.
// [R5] Strobe low forces 0 dB emphasis and equalizer off, whatever else happens.
// [R6] Host keeps the strobe high while the settings must remain applied.
// [R7] Strobe capture and clearing never depend on a serial clock edge.
// [R8] Four latched code bits select one of sixteen emphasis levels.
// [R9] After start-up the applied emphasis level is the 0 dB code.
// [R10] Fifth latched bit high routes data through the equalizer, low bypasses it.
// [R11] After start-up the equalizer enable is low.
// [R12] Serial output is the last stage: input reappears five clocks later.
// [R13] On the fifth edge the first bit leaves with that clock edge.
// [R14] In a cascade host shifts all bits with strobe low, then raises it once.
// [R15] Serial clock output is a buffered copy of the serial clock input.
module secp_config_port (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire logic                              serial_config_clock_in,
  input  wire logic                              serial_config_in,
  input  wire logic                              config_load_strobe,
  output logic                                   serial_config_out,
  output logic                                   serial_config_clock_out,
  output logic [secp_pkg::SECP_EMPH_W-1:0]       emphasis_level,
  output logic                                   equalizer_select,
  output logic                                   config_applied
);
  import secp_pkg::*;

  // ********************************************************************
  // Link side: serial shift register
  // ********************************************************************
  logic                  link_rst_n;
  logic [SECP_CFG_W-1:0] shift_r;
  logic [SECP_CFG_W-1:0] shift_nxt;
  logic [2:0]            link_cnt_r;
  logic [2:0]            link_cnt_nxt;

  // Reset reaches the link domain through its own synchroniser, so it only
  // takes effect once the host clocks; the register is data, not control.
  secp_sync #(
    .WIDTH (1)
  ) u_link_rst_sync (
    .clk      (serial_config_clock_in),
    .async_in (nrst),
    .sync_out (link_rst_n)
  );

  // Each rising serial edge out of link reset moves every bit up one stage and takes a new one.
  always_comb begin
    if (!link_rst_n) begin
      shift_nxt = SECP_CFG_RST;
    end else begin
      shift_nxt = {shift_r[SECP_CFG_W-2:0], serial_config_in};  // R1
    end
  end

  // Edge counter, saturating, used by the checks below to know the fill level.
  always_comb begin
    if (!link_rst_n) begin
      link_cnt_nxt = 3'h0;
    end else if (link_cnt_r == 3'h7) begin
      link_cnt_nxt = link_cnt_r;
    end else begin
      link_cnt_nxt = link_cnt_r + 3'h1;
    end
  end

  // Only the serial clock moves the register; the system clock never does.
  always_ff @(posedge serial_config_clock_in) begin
    shift_r    <= shift_nxt;  // R2
    link_cnt_r <= link_cnt_nxt;
  end

  // The last stage leaves as the cascade data, changing on the same edge
  // that the forwarded clock carries downstream.
  assign serial_config_out       = shift_r[SECP_OUT_POS];  // R12 R13
  assign serial_config_clock_out = serial_config_clock_in;  // R15

  // ********************************************************************
  // Strobe capture
  // ********************************************************************
  logic [SECP_CFG_W-1:0] held_r;
  logic [SECP_CFG_W-1:0] held_nxt;

  // The strobe is its own clock, so the capture needs no serial edge. Host
  // setup time keeps the shift register quiet around the strobe edge.
  always_comb begin
    held_nxt = shift_r;
  end

  always_ff @(posedge config_load_strobe) begin
    held_r <= held_nxt;  // R4 R7
  end

  // ********************************************************************
  // System side: applied settings
  // ********************************************************************
  logic                   strobe_s;
  secp_state_e            st_r;
  secp_state_e            st_nxt;
  logic [SECP_EMPH_W-1:0] emph_r;
  logic [SECP_EMPH_W-1:0] emph_nxt;
  logic                   eq_r;
  logic                   eq_nxt;

  // The strobe level crosses into the system domain before any decision.
  secp_sync #(
    .WIDTH (1)
  ) u_strobe_sync (
    .clk      (clk),
    .async_in (config_load_strobe),
    .sync_out (strobe_s)
  );

  // The captured word is read only after the strobe has stood high for two
  // system cycles, long after it stopped changing; this is the handshake
  // that lets five bits cross without gray coding.
  always_comb begin
    case (st_r)
      SECP_ST_CLEAR: begin
        st_nxt = strobe_s ? SECP_ST_SETTLE : SECP_ST_CLEAR;
      end
      SECP_ST_SETTLE: begin
        st_nxt = strobe_s ? SECP_ST_HOLD : SECP_ST_CLEAR;
      end
      SECP_ST_HOLD: begin
        st_nxt = strobe_s ? SECP_ST_HOLD : SECP_ST_CLEAR;  // R7
      end
      default: begin
        st_nxt = SECP_ST_CLEAR;
      end
    endcase
  end

  // Settings are applied only in the hold state; a low strobe clears them.
  always_comb begin
    if (st_nxt == SECP_ST_HOLD) begin
      emph_nxt = held_r[SECP_EMPH_MSB:SECP_EMPH_LSB];  // R8
      eq_nxt   = held_r[SECP_EQ_POS];                   // R10
    end else begin
      emph_nxt = SECP_EMPH_RST;  // R4 R5
      eq_nxt   = SECP_EQ_RST;    // R5
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r   <= SECP_ST_CLEAR;
      emph_r <= SECP_EMPH_RST;  // R9
      eq_r   <= SECP_EQ_RST;    // R11
    end else begin
      st_r   <= st_nxt;
      emph_r <= emph_nxt;
      eq_r   <= eq_nxt;
    end
  end

  assign emphasis_level   = emph_r;
  assign equalizer_select = eq_r;
  assign config_applied   = (st_r == SECP_ST_HOLD);

  // ********************************************************************
  // Checks on the link side
  // ********************************************************************
  property p_shift_take;
    @(posedge serial_config_clock_in) disable iff (!link_rst_n)
      (link_cnt_r >= 3'h2) |-> shift_r[1] == $past(serial_config_in, 2);
  endproperty
  a_shift_take: assert property (p_shift_take)  // R1
    else $error("Shift stage one does not hold the bit taken two edges ago.");

  property p_out_delay;
    @(posedge serial_config_clock_in) disable iff (!link_rst_n)
      (link_cnt_r >= SECP_CNT_FULL) |-> serial_config_out == $past(serial_config_in, 5);
  endproperty
  a_out_delay: assert property (p_out_delay)  // R12
    else $error("Serial output is not the input delayed by five edges.");

  // A serial clock that sat still between two system edges cannot have moved
  // the register; a negedge sample would see every legal shift as a move.
  property p_no_idle_move;
    @(posedge clk) disable iff (!link_rst_n)
      (link_cnt_r >= 3'h1) && $stable(serial_config_clock_in) |-> $stable(shift_r);
  endproperty
  a_no_idle_move: assert property (p_no_idle_move)  // R2
    else $error("Shift register moved without a rising serial edge.");

  // Clocked by the forwarded clock itself, so the first bit is tied to the
  // edge that a downstream device will see.
  property p_cascade_edge;
    @(posedge serial_config_clock_out) disable iff (!link_rst_n)
      (link_cnt_r == 3'h4) |=> serial_config_out == $past(serial_config_in, 5);
  endproperty
  a_cascade_edge: assert property (p_cascade_edge)  // R13
    else $error("First bit did not leave on the fifth serial edge.");

  // Both levels are sampled in the same step, so a zero-delay copy must match.
  property p_clock_copy;
    @(posedge clk) disable iff (!nrst)
      1'b1 |-> serial_config_clock_out == serial_config_clock_in;
  endproperty
  a_clock_copy: assert property (p_clock_copy)  // R15
    else $error("Forwarded serial clock does not follow the input clock.");

  // Every advance moves each stage up by exactly one position.
  property p_shift_step;
    @(posedge serial_config_clock_in) disable iff (!link_rst_n)
      (link_cnt_r >= 3'h1) |-> shift_r[SECP_CFG_W-1:1] == $past(shift_r[SECP_CFG_W-2:0]);
  endproperty
  a_shift_step: assert property (p_shift_step)  // R2
    else $error("Shift register did not move by one stage.");

  // ********************************************************************
  // Checks on the system side
  // ********************************************************************
  property p_low_clears;
    @(posedge clk) disable iff (!nrst)
      !strobe_s |=> (emphasis_level == SECP_EMPH_RST) && !equalizer_select;
  endproperty
  a_low_clears: assert property (p_low_clears)  // R5
    else $error("Settings not cleared one cycle after the strobe fell.");

  property p_no_early;
    @(posedge clk) disable iff (!nrst)
      !config_applied |-> (emphasis_level == SECP_EMPH_RST) && !equalizer_select;
  endproperty
  a_no_early: assert property (p_no_early)  // R4
    else $error("Settings applied before the strobe capture completed.");

  property p_apply_time;
    @(posedge clk) disable iff (!nrst)
      strobe_s [*2] |=> config_applied;
  endproperty
  a_apply_time: assert property (p_apply_time)  // R7
    else $error("Captured settings not applied after two high strobe cycles.");

  property p_code_map;
    @(posedge clk) disable iff (!nrst)
      $rose(config_applied) |-> emphasis_level == held_r[SECP_EMPH_MSB:SECP_EMPH_LSB];
  endproperty
  a_code_map: assert property (p_code_map)  // R8
    else $error("Applied emphasis code differs from the captured bits.");

  property p_eq_map;
    @(posedge clk) disable iff (!nrst)
      $rose(config_applied) |-> equalizer_select == held_r[SECP_EQ_POS];
  endproperty
  a_eq_map: assert property (p_eq_map)  // R10
    else $error("Applied equalizer enable differs from the fifth bit.");

  property p_start_emph;
    @(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> emphasis_level == SECP_EMPH_RST;
  endproperty
  a_start_emph: assert property (p_start_emph)  // R9
    else $error("Emphasis level not at 0 dB after reset.");

  property p_start_eq;
    @(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> !equalizer_select ##1 !equalizer_select;
  endproperty
  a_start_eq: assert property (p_start_eq)  // R11
    else $error("Equalizer enabled straight after reset.");

  // Applied settings must not drift while the strobe stays high, even when
  // the host keeps shifting new bits through the register.
  property p_hold_steady;
    @(posedge clk) disable iff (!nrst)
      config_applied && $past(config_applied) |->
        $stable(emphasis_level) && $stable(equalizer_select);
  endproperty
  a_hold_steady: assert property (p_hold_steady)  // R4
    else $error("Applied settings changed while the strobe stayed high.");

  // A low strobe drops the applied flag on the next system edge.
  property p_low_unapplied;
    @(posedge clk) disable iff (!nrst)
      !strobe_s |=> !config_applied;
  endproperty
  a_low_unapplied: assert property (p_low_unapplied)  // R5
    else $error("Settings still marked applied after the strobe went low.");

  // A fresh strobe rise is not applied at once; the settle step comes first.
  property p_rise_wait;
    @(posedge clk) disable iff (!nrst)
      $rose(strobe_s) |=> !config_applied;
  endproperty
  a_rise_wait: assert property (p_rise_wait)  // R4
    else $error("Settings applied without the settle cycle.");

  // ********************************************************************
  // Scenario coverage
  // ********************************************************************
  c_apply_eq: cover property (@(posedge clk) disable iff (!nrst)
    $rose(config_applied) && equalizer_select);
  c_apply_max: cover property (@(posedge clk) disable iff (!nrst)
    config_applied && (emphasis_level == 4'hf));
  c_release: cover property (@(posedge clk) disable iff (!nrst)
    $fell(config_applied));
  c_cascade: cover property (@(posedge serial_config_clock_in) disable iff (!link_rst_n)
    link_cnt_r == 3'h7);

endmodule

// File: design/secp_pkg.sv
// Constants shared by the serial emphasis configuration port.
// Assumes a 40 MHz system clock and a serial clock that the host drives.
package secp_pkg;

  // ********************************************************************
  // Shift register and field layout
  // ********************************************************************
  localparam int unsigned SECP_CFG_W     = 5;  // Stages in the serial shift register.
  localparam int unsigned SECP_EMPH_W    = 4;  // Width of the emphasis code.
  localparam int unsigned SECP_EMPH_LSB  = 1;  // Emphasis code sits above the enable bit.
  localparam int unsigned SECP_EMPH_MSB  = 4;  // First bit shifted in ends here.
  localparam int unsigned SECP_EQ_POS    = 0;  // Last bit shifted in is the equalizer enable.
  localparam int unsigned SECP_OUT_POS   = 4;  // Final stage drives the cascade output.
  localparam int unsigned SECP_SYNC_LEN  = 2;  // Flip-flops in each synchroniser.

  // ********************************************************************
  // Reset and cleared values
  // ********************************************************************
  localparam logic [4:0] SECP_CFG_RST   = 5'h00;  // Shift register after reset.
  localparam logic [3:0] SECP_EMPH_RST  = 4'h0;   // Code for the 0 dB setting.
  localparam logic       SECP_EQ_RST    = 1'b0;   // Equalizer bypassed.
  localparam logic [2:0] SECP_CNT_FULL  = 3'h5;   // Edges needed to fill the register.

  // ********************************************************************
  // Control states of the applied-setting logic
  // ********************************************************************
  typedef enum logic [2:0] {
    SECP_ST_CLEAR  = 3'b001,
    SECP_ST_SETTLE = 3'b010,
    SECP_ST_HOLD   = 3'b100
  } secp_state_e;

endpackage

// File: design/secp_sync.sv
// Two-stage synchroniser for level signals, one bit per lane.
// Assumes the input is a slow level that may change at any time.
`timescale 1ns/1ps

module secp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import secp_pkg::*;

  // ********************************************************************
  // Synchroniser stages
  // ********************************************************************
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // No reset here: the stages flush within two edges of any clock.
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;

endmodule

// File: dv/secp_host.sv
// Host model for the serial configuration port: clocks frames in and drives the strobe.
// Assumes the bench calls its tasks from one process, one task at a time.
`timescale 1ns/1ps

module secp_host (
  input  wire logic clk,
  input  wire logic serial_config_out,
  output logic      serial_config_clock_in,
  output logic      serial_config_in,
  output logic      config_load_strobe
);
  // ********************************************************************
  // Serial frames and strobe
  // ********************************************************************
  // All lines idle low until the first frame; the strobe low keeps settings cleared.
  initial begin
    serial_config_clock_in = 1'b0;
    serial_config_in       = 1'b0;
    config_load_strobe     = 1'b0;
  end

  // Shifts the top n bits of word, first bit first, at a 160 ns period.
  // The clock stands still between frames, and once the hold time has passed the data
  // line shows the inverse bit, so a late sample cannot pass by luck.
  task automatic send(input logic [4:0] word, input int n, output logic [4:0] seen);
    seen = 5'h00;
    for (int k = 0; k < n; k++) begin
      serial_config_in = word[4-k];
      #41.3;
      serial_config_clock_in = 1'b1;
      #20.0;
      serial_config_in = ~word[4-k];
      seen = {seen[3:0], serial_config_out};
      #60.0;
      serial_config_clock_in = 1'b0;
      #38.7;
    end
  endtask

  // Moves the strobe off the system clock edge; it stays high while settings must hold.
  task automatic load(input logic lvl);
    @(negedge clk);
    config_load_strobe = lvl;
  endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the serial emphasis configuration port.
// Assumes the host model in secp_host.sv drives the serial side.
`timescale 1ns/1ps

module tb;
  import secp_pkg::*;
  typedef struct packed {logic [4:0] word; logic [3:0] lvl; logic eq;} secp_row_s;
  logic       clk;
  logic       nrst;
  logic       sck;
  logic       serial_config_port;
  logic       ld;
  logic       sdo;
  logic       sck_o;
  logic [3:0] lvl;
  logic       eqs;
  logic       app;
  logic [4:0] seen;
  logic [4:0] prev;
  int         err_count = 0;
  int         checked = 0;
  secp_row_s  rows [16] = '{
    '{5'h00, 4'h0, 1'b0}, '{5'h02, 4'h1, 1'b0}, '{5'h05, 4'h2, 1'b1}, '{5'h07, 4'h3, 1'b1},
    '{5'h08, 4'h4, 1'b0}, '{5'h0a, 4'h5, 1'b0}, '{5'h0d, 4'h6, 1'b1}, '{5'h0f, 4'h7, 1'b1},
    '{5'h10, 4'h8, 1'b0}, '{5'h12, 4'h9, 1'b0}, '{5'h15, 4'ha, 1'b1}, '{5'h17, 4'hb, 1'b1},
    '{5'h18, 4'hc, 1'b0}, '{5'h1a, 4'hd, 1'b0}, '{5'h1d, 4'he, 1'b1}, '{5'h1f, 4'hf, 1'b1}};

  secp_config_port i_secp_config_port (
    .clk                     (clk),
    .nrst                    (nrst),
    .serial_config_clock_in  (sck),
    .serial_config_in        (serial_config_port),
    .config_load_strobe      (ld),
    .serial_config_out       (sdo),
    .serial_config_clock_out (sck_o),
    .emphasis_level          (lvl),
    .equalizer_select        (eqs),
    .config_applied          (app)
  );
  secp_host i_secp_host (
    .clk                    (clk),
    .serial_config_out      (sdo),
    .serial_config_clock_in (sck),
    .serial_config_in       (serial_config_port),
    .config_load_strobe     (ld)
  );

  // ********************************************************************
  // Checking helpers
  // ********************************************************************
  // The 40 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The forwarded clock is compared shortly after every change of its source.
  always @(sck) begin
    #1 check("clock_out", {4'h0, sck_o}, {4'h0, sck});
  end

  task automatic check(input string name, input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic expect_out(input logic [3:0] l, input logic e, input logic a);
    check("emphasis_level", {1'b0, lvl}, {1'b0, l});
    check("equalizer_select", {4'h0, eqs}, {4'h0, e});
    check("config_applied", {4'h0, app}, {4'h0, a});
  endtask

  // A strobe change shows within a few cycles; a longer wait is a hang and ends the run.
  task automatic wait_app(input logic v);
    int n;
    n = 0;
    while (app !== v && n < 12) begin
      @(negedge clk);
      n++;
    end
    check("applied_wait", {4'h0, app}, {4'h0, v});
    if (app !== v) print_verdict();
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  // Reset, the table of all sixteen codes, then the awkward cases.
  initial begin
    // The link reset only acts on serial edges: two of them fall inside the
    // reset, the rest flush the link synchroniser before the first frame.
    nrst = 1'b0;
    fork
      i_secp_host.send(5'h00, 5, seen);
    join_none
    repeat (10) @(negedge clk);
    expect_out(4'h0, 1'b0, 1'b0);
    nrst = 1'b1;
    wait fork;
    foreach (rows[i]) begin
      i_secp_host.send(rows[i].word, 5, seen);
      if (i > 0) check("serial_out", seen, {prev[3:0], rows[i].word[4]});
      repeat (4) @(negedge clk);
      expect_out(4'h0, 1'b0, 1'b0);
      i_secp_host.load(1'b1);
      wait_app(1'b1);
      expect_out(rows[i].lvl, rows[i].eq, 1'b1);
      i_secp_host.load(1'b0);
      wait_app(1'b0);
      prev = rows[i].word;
    end
    // Shifting under a high strobe must leave the applied word alone.
    i_secp_host.load(1'b1);
    wait_app(1'b1);
    i_secp_host.send(5'h06, 5, seen);
    check("serial_out", seen, {4'hf, 1'b0});
    expect_out(4'hf, 1'b1, 1'b1);
    // A strobe rise in mid-frame takes the register as it stands.
    i_secp_host.load(1'b0);
    wait_app(1'b0);
    i_secp_host.send(5'h00, 3, seen);
    i_secp_host.load(1'b1);
    wait_app(1'b1);
    expect_out(4'h8, 1'b0, 1'b1);
    // A second reset while settings are applied clears them.
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    expect_out(4'h0, 1'b0, 1'b0);
    nrst = 1'b1;
    i_secp_host.load(1'b0);
    wait_app(1'b0);
    print_verdict();
  end
endmodule
